// [logic/pic_params.svh]
// constants of the prioritized interrupt controller
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH
`define PIC_NUM_CH 32
`define PIC_NUM_SCR 8
`define PIC_ADDR_W 9
`define PIC_IMPL_MASK 32'h6fc8_fcfa
`define PIC_SCR_RESET 32'h4747_4747
`define PIC_LEVEL_IDLE 4'h8
`define PIC_STACK_DEPTH 8
`define PIC_CH_WATCHDOG 1
`define PIC_CH_PIN_GROUP0 3
`define PIC_CH_AUDIO 7
`define PIC_CH_SERIAL_MS 27
`define PIC_CH_WAKEUP 29
`define PIC_CH_FLASH_SERIAL 30
`define PIC_OFS_SCR_FIRST 9'h000
`define PIC_OFS_SCR_LAST 9'h01c
`define PIC_OFS_RAW_STATUS 9'h100
`define PIC_OFS_ACTIVE_STATUS 9'h104
`define PIC_OFS_STATUS 9'h108
`define PIC_OFS_PRIORITY_ENCODING 9'h10c
`define PIC_OFS_SOURCE_NUMBER 9'h110
`define PIC_OFS_MASK_STATUS 9'h114
`define PIC_OFS_MASK_ENABLE 9'h118
`define PIC_OFS_MASK_DISABLE 9'h11c
`define PIC_OFS_SOURCE_SET 9'h120
`define PIC_OFS_SOURCE_CLEAR 9'h124
`define PIC_OFS_END_OF_SERVICE 9'h128
`endif

// [logic/pic_pkg.sv]
// types of the prioritized interrupt controller
package pic_pkg;
    typedef enum logic [1:0] {
        PIC_SENS_HIGH = 2'h0,
        PIC_SENS_LOW = 2'h1,
        PIC_SENS_FALL = 2'h2,
        PIC_SENS_RISE = 2'h3
    } pic_sens_e;

    typedef struct packed {
        pic_sens_e sens;
        logic [2:0] rsv;
        logic [2:0] prio;
    } pic_chan_s;

    typedef struct packed {
        logic read;
        logic write;
        logic [8:0] address;
        logic [31:0] writedata;
    } pic_avs_req_s;
endpackage : pic_pkg

// [logic/pic_top.sv]
// prioritized interrupt controller with avalon-mm register slave
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "pic_params.svh"

module pic_top #(
    parameter int NUM_CH = `PIC_NUM_CH,
    parameter int STACK_DEPTH = `PIC_STACK_DEPTH,
    parameter logic [31:0] IMPL_MASK = `PIC_IMPL_MASK
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire pic_pkg::pic_avs_req_s avsReq,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic watchdog_request,
    input wire logic [3:0] pin_group0_request,
    input wire logic audio_unit_request,
    input wire logic serial_periph_ms_request,
    input wire logic wakeup_request,
    input wire logic flash_serial_master_request,
    input wire logic [31:0] otherRequest,
    output logic normal_irq_request_n,
    output logic fast_irq_request_n
);
    import pic_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // source assembly

    logic [31:0] srcVec;
    always_comb
    begin
        srcVec = otherRequest;
        srcVec[`PIC_CH_WATCHDOG] = watchdog_request;
        srcVec[`PIC_CH_PIN_GROUP0 +: 4] = pin_group0_request;
        srcVec[`PIC_CH_AUDIO] = audio_unit_request;
        srcVec[`PIC_CH_SERIAL_MS] = serial_periph_ms_request;
        srcVec[`PIC_CH_WAKEUP] = wakeup_request;
        srcVec[`PIC_CH_FLASH_SERIAL] = flash_serial_master_request;
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake: every access takes one wait cycle

    logic ackQ;
    logic busReq;
    logic take;
    assign busReq = avsReq.read | avsReq.write;
    assign take = busReq & ~ackQ;
    assign avs_waitrequest = busReq & ~ackQ;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            ackQ <= 1'b0;
        else
            ackQ <= take;
    end

    logic wrTake;
    logic rdTake;
    assign wrTake = take & avsReq.write;
    assign rdTake = take & avsReq.read;

    logic isScr;
    assign isScr = avsReq.address <= `PIC_OFS_SCR_LAST && avsReq.address[1:0] == 2'h0;
    logic [2:0] scrIdx;
    assign scrIdx = avsReq.address[4:2];

    logic rdEncoding;
    logic wrEos;
    assign rdEncoding = rdTake && avsReq.address == `PIC_OFS_PRIORITY_ENCODING;
    assign wrEos = wrTake && avsReq.address == `PIC_OFS_END_OF_SERVICE;

    ////////////////////////////////////////////////////////////////////////////
    // source control registers

    logic [31:0] scrQ [`PIC_NUM_SCR];
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < `PIC_NUM_SCR; i++)
                scrQ[i] <= `PIC_SCR_RESET;
        end
        else if (wrTake && isScr)
            scrQ[scrIdx] <= avsReq.writedata;
    end

    logic [31:0] enQ;
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            enQ <= 32'h0;
        else if (wrTake && avsReq.address == `PIC_OFS_MASK_ENABLE)
            enQ <= enQ | avsReq.writedata;
        else if (wrTake && avsReq.address == `PIC_OFS_MASK_DISABLE)
            enQ <= enQ & ~avsReq.writedata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel detection

    logic [31:0] prevQ;
    logic [31:0] edgeQ;
    logic [31:0] edgeHit;
    logic [31:0] pending;
    logic [31:0] act;
    logic [31:0] isEdge;
    logic [31:0] ackClr;
    logic [2:0] prio [NUM_CH];

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            prevQ <= 32'h0;
        else
            prevQ <= srcVec;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : gCh
            pic_chan_s ctl;
            assign ctl = scrQ[g / 4][8 * (g % 4) +: 8];
            assign prio[g] = ctl.prio;
            assign isEdge[g] = ctl.sens[1];
            assign edgeHit[g] = (ctl.sens == PIC_SENS_RISE && srcVec[g] && !prevQ[g])
                || (ctl.sens == PIC_SENS_FALL && !srcVec[g] && prevQ[g]);

            always_ff @(posedge ref_clk or negedge arst_n)
            begin
                if (!arst_n)
                    edgeQ[g] <= 1'b0;
                // set wins over any clear in the same cycle
                else if (edgeHit[g]
                    || (wrTake && avsReq.address == `PIC_OFS_SOURCE_SET && avsReq.writedata[g] && isEdge[g]))
                    edgeQ[g] <= 1'b1;
                else if (ackClr[g]
                    || (wrTake && avsReq.address == `PIC_OFS_SOURCE_CLEAR && avsReq.writedata[g]))
                    edgeQ[g] <= 1'b0;
            end

            always_comb
            begin
                unique case (ctl.sens)
                    PIC_SENS_HIGH: pending[g] = srcVec[g];
                    PIC_SENS_LOW: pending[g] = !srcVec[g];
                    PIC_SENS_FALL,
                    PIC_SENS_RISE: pending[g] = edgeQ[g];
                endcase
            end
            assign act[g] = pending[g] & enQ[g] & IMPL_MASK[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // priority resolution

    logic candValid;
    logic [4:0] candCh;
    logic [2:0] candPrio;
    logic fiqAny;
    always_comb
    begin
        candValid = 1'b0;
        candCh = 5'h0;
        candPrio = 3'h7;
        fiqAny = 1'b0;
        // descending scan with <= lets the lower channel win ties
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            if (act[i] && (!candValid || prio[i] <= candPrio))
            begin
                candValid = 1'b1;
                candCh = 5'(i);
                candPrio = prio[i];
            end
            if (act[i] && prio[i] == 3'h0)
                fiqAny = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // current level and nesting stack

    logic [3:0] curLevelQ;
    logic [3:0] stackQ [STACK_DEPTH];
    logic [3:0] spQ;
    logic higher;
    logic grant;
    // only strictly higher than the level in service
    assign higher = candValid && {1'b0, candPrio} < curLevelQ;
    assign grant = rdEncoding && higher;

    always_comb
    begin
        ackClr = 32'h0;
        // the granted edge winner is acknowledged
        if (grant && isEdge[candCh])
            ackClr[candCh] = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            curLevelQ <= `PIC_LEVEL_IDLE;
            spQ <= 4'h0;
            for (int i = 0; i < STACK_DEPTH; i++)
                stackQ[i] <= `PIC_LEVEL_IDLE;
        end
        else if (grant)
        begin
            // stack overflow drops the push; nesting deeper than levels is impossible
            if (spQ < 4'(STACK_DEPTH))
            begin
                stackQ[spQ[2:0]] <= curLevelQ;
                spQ <= spQ + 4'h1;
            end
            curLevelQ <= {1'b0, candPrio};
        end
        else if (wrEos && spQ != 4'h0)
        begin
            curLevelQ <= stackQ[3'(spQ - 4'h1)];
            spQ <= spQ - 4'h1;
        end
    end

    logic [4:0] srcNumQ;
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            srcNumQ <= 5'h0;
        else if (grant)
            srcNumQ <= candCh;
    end

    ////////////////////////////////////////////////////////////////////////////
    // request lines, active low, from flops

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            normal_irq_request_n <= 1'b1;
            fast_irq_request_n <= 1'b1;
        end
        else
        begin
            // normal line for levels above zero, higher than current
            normal_irq_request_n <= !(higher && candPrio != 3'h0 && !grant);
            // fast line ignores the normal service level
            fast_irq_request_n <= !fiqAny;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data

    logic [31:0] rdVal;
    always_comb
    begin
        rdVal = 32'h0;
        if (isScr)
            rdVal = scrQ[scrIdx];
        else
        begin
            unique case (avsReq.address)
                `PIC_OFS_RAW_STATUS: rdVal = srcVec & IMPL_MASK;
                `PIC_OFS_ACTIVE_STATUS: rdVal = pending & IMPL_MASK;
                `PIC_OFS_STATUS: rdVal = act;
                `PIC_OFS_PRIORITY_ENCODING: rdVal = higher ? {25'h0, candCh, 2'h0} : 32'h0;
                `PIC_OFS_SOURCE_NUMBER: rdVal = {27'h0, srcNumQ};
                `PIC_OFS_MASK_STATUS: rdVal = enQ;
                default: rdVal = 32'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            avs_readdata <= 32'h0;
        else if (rdTake)
            avs_readdata <= rdVal;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    AST_WAIT_ONE: assert property (take |=> !avs_waitrequest)
        else $error("bus answer not given one cycle after take");
    AST_NESTED_REQ: assert property (higher && candPrio != 3'h0 && !grant |=> !normal_irq_request_n)
        else $error("normal line not asserted for higher source");
    AST_SUPPRESS: assert property (!higher |=> normal_irq_request_n)
        else $error("normal line asserted for non-higher source");
    AST_FAST_LINE: assert property (fiqAny |=> !fast_irq_request_n)
        else $error("fast line missing for level zero source");
    AST_FAST_ONLY_ZERO: assert property (!fiqAny |=> fast_irq_request_n)
        else $error("fast line asserted without level zero source");
    AST_MASKED_QUIET: assert property ((act & ~enQ) == 32'h0)
        else $error("masked channel active");
    AST_RESERVED_QUIET: assert property ((act & ~IMPL_MASK) == 32'h0)
        else $error("unassigned channel active");
    AST_VECTOR: assert property (grant |=> avs_readdata == {25'h0, $past(candCh), 2'h0}
        && curLevelQ == {1'b0, $past(candPrio)})
        else $error("vector or level wrong after encoding read");
    AST_FAKE: assert property (rdEncoding && !higher |=> avs_readdata == 32'h0 && $stable(curLevelQ))
        else $error("fake read changed state or returned nonzero");
    AST_EDGE_CLEAR: assert property (grant && isEdge[candCh] && !edgeHit[candCh]
        |=> !edgeQ[$past(candCh)])
        else $error("edge flag not cleared on service");
    AST_EOS_POP: assert property (wrEos && !grant && spQ != 4'h0
        |=> curLevelQ == $past(stackQ[3'(spQ - 4'h1)]) && spQ == $past(spQ) - 4'h1)
        else $error("end of service did not restore level");
    AST_GRANT_DROP: assert property (grant |=> normal_irq_request_n)
        else $error("normal line not dropped after encoding read");

    // covers of the main service paths
    COV_NEST: cover property (grant ##[1:20] grant);
    COV_FAST_DURING_NORMAL: cover property (curLevelQ != `PIC_LEVEL_IDLE && !fast_irq_request_n);
    COV_FAKE: cover property (rdEncoding && !higher);
    COV_EOS: cover property (wrEos && spQ != 4'h0);
    COV_EDGE_SERVICE: cover property (grant && isEdge[candCh]);
endmodule : pic_top

// [tb/pic_cpu_model.sv]
// processor-side model of the two interrupt request inputs
`timescale 1ns/10ps

module pic_cpu_model (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic normal_irq_request_n,
    input wire logic fast_irq_request_n,
    input wire logic irqOff,
    input wire logic fiqOff,
    output logic irqTaken,
    output logic fiqTaken
);
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irqTaken <= 1'b0;
            fiqTaken <= 1'b0;
        end
        else
        begin
            irqTaken <= !normal_irq_request_n && !irqOff;
            fiqTaken <= !fast_irq_request_n && !fiqOff;
        end
    end
endmodule : pic_cpu_model

// [tb/tb.sv]
// self-checking bench of the prioritized interrupt controller
`timescale 1ns/10ps
`include "pic_params.svh"

module tb;
    import pic_pkg::*;
    localparam logic [31:0] IMPL = `PIC_IMPL_MASK;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    pic_avs_req_s avsReq = '0;
    logic [31:0] rdData, rd, msk;
    logic [31:0] src = '0;
    logic waitReq, nIrqN, fIrqN, irqTaken, fiqTaken;
    logic [2:0] pr [32];
    pic_sens_e sn [32];
    int lvl = 8;
    int seed = 40;
    int n_mismatch = 0;
    int tests_run = 0;
    int stk [$];

    always #5 ref_clk = ~ref_clk;

    pic_top i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .avsReq(avsReq), .avs_readdata(rdData),
        .avs_waitrequest(waitReq), .watchdog_request(src[1]), .pin_group0_request(src[6:3]),
        .audio_unit_request(src[7]), .serial_periph_ms_request(src[27]), .wakeup_request(src[29]),
        .flash_serial_master_request(src[30]), .otherRequest(src), .normal_irq_request_n(nIrqN),
        .fast_irq_request_n(fIrqN));

    pic_cpu_model i_cpu (.ref_clk(ref_clk), .arst_n(arst_n), .normal_irq_request_n(nIrqN),
        .fast_irq_request_n(fIrqN), .irqOff(1'b0), .fiqOff(1'b0), .irqTaken(irqTaken), .fiqTaken(fiqTaken));

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp

    // request held until waitrequest seen low at a rising edge
    task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        avsReq <= '{!wr, wr, a, d};
        // waitrequest is read at each rising edge, before the slave's flops update
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (waitReq !== 1'b0 && k < 50);
        if (waitReq !== 1'b0)
        begin
            n_mismatch++;
            $display("[ERR] %0t bus timeout", $time);
            test_done();
        end
        rd = rdData;
        avsReq.read <= 1'b0;
        avsReq.write <= 1'b0;
    endtask : bus

    task automatic setcfg();
        logic [31:0] v;
        for (int r = 0; r < 8; r++)
        begin
            for (int i = 0; i < 4; i++)
                v[8*i+:8] = {sn[4*r+i], 3'h0, pr[4*r+i]};
            bus(1'b1, 9'(4 * r), v);
        end
    endtask : setcfg

    function automatic int best(input logic [31:0] e);
        best = -1;
        for (int c = 31; c >= 0; c--)
            if (e[c] && (best < 0 || pr[c] <= pr[best]))
                best = c;
    endfunction : best

    // lines are registered: three edges cover sampling plus output flop
    task automatic waitchk();
        logic [31:0] e;
        logic nExp, fExp;
        int c;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        e = src & msk & IMPL;
        nExp = 1'b1;
        fExp = 1'b1;
        for (int j = 0; j < 32; j++)
            if (e[j] && pr[j] == 0)
                fExp = 1'b0;
        // normal line follows the overall winner; a level-zero winner is left to the fast line
        c = best(e);
        if (c >= 0 && pr[c] != 0 && pr[c] < lvl)
            nExp = 1'b0;
        cmp(nIrqN, nExp, "normal line");
        cmp(fIrqN, fExp, "fast line");
        bus(1'b0, `PIC_OFS_STATUS, '0);
        cmp(rd, e, "status");
    endtask : waitchk

    task automatic stchk(input logic e);
        repeat (3) @(posedge ref_clk);
        bus(1'b0, `PIC_OFS_STATUS, '0);
        cmp(rd[14], e, "edge status");
    endtask : stchk

    task automatic iper(input logic [31:0] e);
        int c;
        c = best(e);
        if (c >= 0 && pr[c] >= lvl)
            c = -1;
        bus(1'b0, `PIC_OFS_PRIORITY_ENCODING, '0);
        cmp(rd, (c < 0) ? 32'h0 : 32'(4 * c), "encoding");
        if (c >= 0)
        begin
            stk.push_back(lvl);
            lvl = pr[c];
        end
    endtask : iper

    task automatic eos();
        bus(1'b1, `PIC_OFS_END_OF_SERVICE, '0);
        lvl = (stk.size() > 0) ? stk.pop_back() : 8;
    endtask : eos

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        msk = '0;
        for (int c = 0; c < 32; c++)
        begin
            pr[c] = 3'h7;
            sn[c] = PIC_SENS_HIGH;
        end
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        for (int r = 0; r < 8; r++)
        begin
            bus(1'b0, 9'(4 * r), '0);
            cmp(rd, `PIC_SCR_RESET, "control reset");
        end
        bus(1'b0, 9'h1fc, '0);
        cmp(rd, 32'h0, "unmapped");
        iper(32'h0);
        // random priorities, masks and sources, all high level
        repeat (40)
        begin
            for (int c = 0; c < 32; c++)
                pr[c] = 3'($random(seed));
            setcfg();
            msk = $random(seed);
            bus(1'b1, `PIC_OFS_MASK_DISABLE, ~msk);
            bus(1'b1, `PIC_OFS_MASK_ENABLE, msk);
            bus(1'b0, `PIC_OFS_MASK_STATUS, '0);
            cmp(rd, msk, "mask status");
            src <= $random(seed);
            waitchk();
            iper(src & msk & IMPL);
            waitchk();
            eos();
        end
        // nesting on channels 10 to 13
        src <= '0;
        msk = 32'h0000_3c00;
        bus(1'b1, `PIC_OFS_MASK_DISABLE, ~msk);
        bus(1'b1, `PIC_OFS_MASK_ENABLE, msk);
        for (int c = 0; c < 32; c++)
            pr[c] = 3'h7;
        pr[10] = 3'h5;
        pr[11] = 3'h2;
        pr[12] = 3'h6;
        pr[13] = 3'h0;
        setcfg();
        src <= 32'h0000_0400;
        waitchk();
        cmp(irqTaken, 1'b1, "core normal");
        iper(src & msk & IMPL);
        waitchk();
        src <= 32'h0000_1400;
        waitchk();
        src <= 32'h0000_3400;
        waitchk();
        cmp(fiqTaken, 1'b1, "core fast");
        src <= 32'h0000_1c00;
        waitchk();
        iper(src & msk & IMPL);
        src <= 32'h0000_1400;
        waitchk();
        eos();
        waitchk();
        eos();
        waitchk();
        // each sensitivity on channel 14
        src <= '0;
        msk = 32'h0000_4000;
        bus(1'b1, `PIC_OFS_MASK_DISABLE, ~msk);
        bus(1'b1, `PIC_OFS_MASK_ENABLE, msk);
        pr[14] = 3'h3;
        for (int m = 0; m < 4; m++)
        begin
            sn[14] = pic_sens_e'(m);
            setcfg();
            src[14] <= (m == 1 || m == 2);
            stchk(1'b0);
            src[14] <= !(m == 1 || m == 2);
            stchk(1'b1);
            src[14] <= (m == 1 || m == 2);
            stchk(m >= 2);
            if (m >= 2)
            begin
                iper(32'h0000_4000);
                bus(1'b0, `PIC_OFS_SOURCE_NUMBER, '0);
                cmp(rd, 32'h0000_000e, "source number");
                stchk(1'b0);
                bus(1'b1, `PIC_OFS_SOURCE_SET, 32'h0000_4000);
                stchk(1'b1);
                bus(1'b1, `PIC_OFS_SOURCE_CLEAR, 32'h0000_4000);
                stchk(1'b0);
                eos();
            end
        end
        test_done();
    end
endmodule : tb
